/* rtl/rfc_pkg.sv */
// Constants for the reference frequency configuration register slice.
// Assumes a byte-wide register port with byte addresses.
package rfc_pkg;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned WORD_W   = 16;
   localparam int unsigned PROD_W   = 32;
   localparam int unsigned NUM_WIDE = 2;

   localparam logic [ADDR_W-1:0] ADDR_FREEZE     = 8'h0D;
   localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'h0E;
   localparam logic [ADDR_W-1:0] ADDR_BASE_HI    = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_BASE_LO    = 8'h11;
   localparam logic [ADDR_W-1:0] ADDR_MULT_HI    = 8'h12;
   localparam logic [ADDR_W-1:0] ADDR_MULT_LO    = 8'h13;

   localparam logic [DATA_W-1:0] FREEZE_RESET    = 8'h00;
   localparam logic [DATA_W-1:0] FREEZE_LOCK     = 8'h01;
   localparam logic [DATA_W-1:0] FREEZE_RELEASE  = 8'h00;
   localparam logic [WORD_W-1:0] BASE_RESET      = 16'h9C40;
   localparam logic [WORD_W-1:0] MULT_RESET      = 16'h0F30;
   localparam logic [DATA_W-1:0] STATUS_RESET    = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ   = 8'h00;

   localparam int unsigned IDX_BASE = 0;
   localparam int unsigned IDX_MULT = 1;
endpackage

/* rtl/rfc_wide_if.sv */
// Carrier between the decoder and one big-endian 16-bit register.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface rfc_wide_if;
   import rfc_pkg::*;
   logic              wr_hi;
   logic              wr_lo;
   logic [DATA_W-1:0] wdata;
   logic [WORD_W-1:0] value;
   modport ctrl  (output wr_hi, output wr_lo, output wdata, input value);
   modport store (input wr_hi, input wr_lo, input wdata, output value);
endinterface

/* rtl/rfc_wide_reg.sv */
// One 16-bit register written one byte at a time, big endian.
// Assumes byte strobes come from the decoder on the same clock.
`timescale 1ns/100ps
module rfc_wide_reg
   import rfc_pkg::*;
#(
   parameter logic [WORD_W-1:0] RESET_VALUE = 16'h0000
) (
   input  wire logic   i_clock,
   input  wire logic   i_reset,
   rfc_wide_if.store   bus
);
   typedef struct packed {
      logic [WORD_W-1:0] value;
   } rfc_wide_state_t;

   rfc_wide_state_t state_q;
   rfc_wide_state_t state_d;

   always_comb begin
      state_d = state_q;
      // Lower address carries the high byte [RULE5]
      if (bus.wr_hi) begin
         state_d.value[WORD_W-1:DATA_W] = bus.wdata;
      end
      if (bus.wr_lo) begin
         state_d.value[DATA_W-1:0] = bus.wdata;
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state_q <= '{value: RESET_VALUE};
      end else begin
         state_q <= state_d;
      end
   end

   assign bus.value = state_q.value;
endmodule

/* rtl/rfc_regs.sv */
// Reference-0 frequency configuration and status freeze register slice.
// Assumes a single-clock byte register port, read data one cycle later.
// Summary of operation
// RULE1 - A freeze byte of 0x01 stops the latched read status from updating.
// RULE2 - Writing 0x00 to the freeze byte lets the status update again.
// RULE3 - The base rate register holds a 16-bit unsigned rate in hertz.
// RULE4 - Software programs the base rate with one of the supported codes.
// RULE5 - Wide registers take the high byte at the lower address.
// RULE6 - The rate multiplier register holds a 16-bit unsigned factor.
// RULE7 - Software makes base rate times multiplier equal the reference rate.
// RULE8 - With halving enabled, software programs half the input rate.
// RULE9 - Wide registers read back the high byte at the lower address.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module rfc_regs
   import rfc_pkg::*;
(
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_wdata,
   input  wire logic              i_write,
   input  wire logic              i_read,
   input  wire logic [DATA_W-1:0] i_status,
   input  wire logic              i_clock,
   input  wire logic              i_reset,
   output logic      [DATA_W-1:0] o_rdata,
   output logic                   o_status_frozen,
   output logic      [WORD_W-1:0] o_base_rate_value,
   output logic      [WORD_W-1:0] o_rate_multiplier_value,
   output logic      [PROD_W-1:0] o_ref_zero_rate_hz
);
   typedef struct packed {
      logic [DATA_W-1:0] freeze;
      logic              frozen;
      logic [DATA_W-1:0] latched_read_status;
      logic [DATA_W-1:0] rdata;
      logic [WORD_W-1:0] base_rate;
      logic [WORD_W-1:0] rate_mult;
      logic [PROD_W-1:0] rate_hz;
   } rfc_state_t;

   localparam rfc_state_t STATE_RESET = '{
      freeze:              FREEZE_RESET,
      frozen:              1'b0,
      latched_read_status: STATUS_RESET,
      rdata:               UNMAPPED_READ,
      base_rate:           BASE_RESET,
      rate_mult:           MULT_RESET,
      rate_hz:             '0
   };

   localparam logic [ADDR_W-1:0] HI_ADDR [NUM_WIDE] =
      '{ADDR_BASE_HI, ADDR_MULT_HI};
   localparam logic [ADDR_W-1:0] LO_ADDR [NUM_WIDE] =
      '{ADDR_BASE_LO, ADDR_MULT_LO};
   localparam logic [WORD_W-1:0] WIDE_RESET [NUM_WIDE] =
      '{BASE_RESET, MULT_RESET};

   rfc_state_t state_q;
   rfc_state_t state_d;

   // Carriers to the wide registers, one per entry
   rfc_wide_if wide [NUM_WIDE] ();
   logic [WORD_W-1:0]   wide_value [NUM_WIDE];

   // Address decode; the two strobes are never high together
   logic                hit_freeze;
   logic                hit_status;
   logic [NUM_WIDE-1:0] hit_hi;
   logic [NUM_WIDE-1:0] hit_lo;
   logic [DATA_W-1:0]   byte_hi [NUM_WIDE];
   logic [DATA_W-1:0]   byte_lo [NUM_WIDE];

   assign hit_freeze = (i_addr == ADDR_FREEZE);
   assign hit_status = (i_addr == ADDR_STATUS);

   genvar g;
   generate
      for (g = 0; g < NUM_WIDE; g++) begin : g_wide
         // Each wide register gets its own byte strobes [RULE5]
         assign hit_hi[g]     = (i_addr == HI_ADDR[g]);
         assign hit_lo[g]     = (i_addr == LO_ADDR[g]);
         assign wide[g].wr_hi = i_write && hit_hi[g];
         assign wide[g].wr_lo = i_write && hit_lo[g];
         assign wide[g].wdata = i_wdata;
         assign wide_value[g] = wide[g].value;

         // High byte sits at the lower address on reads too [RULE9]
         assign byte_hi[g] = wide_value[g][WORD_W-1:DATA_W];
         assign byte_lo[g] = wide_value[g][DATA_W-1:0];

         rfc_wide_reg #(
            .RESET_VALUE (WIDE_RESET[g])
         ) u_wide (
            .i_clock (i_clock),
            .i_reset (i_reset),
            .bus     (wide[g])
         );
      end
   endgenerate

   always_comb begin
      state_d = state_q;

      // Freeze byte takes any value and reads it back unchanged
      if (i_write && hit_freeze) begin
         state_d.freeze = i_wdata;
      end
      // Only the exact lock code freezes; any other value releases
      state_d.frozen = (state_d.freeze == FREEZE_LOCK); // [RULE1] [RULE2]

      // Snapshot holds still while frozen so a multi-read stays coherent
      if (!state_q.frozen) begin
         state_d.latched_read_status = i_status; // [RULE1] [RULE2]
      end

      // Unsigned 16-bit values, registered copies for the outputs
      state_d.base_rate = wide_value[IDX_BASE]; // [RULE3]
      state_d.rate_mult = wide_value[IDX_MULT]; // [RULE6]
      // Product registered on the same edge as the copies it is made of
      state_d.rate_hz = PROD_W'(wide_value[IDX_BASE])
                      * PROD_W'(wide_value[IDX_MULT]);

      // Read data stand one cycle only, then fall back to zero
      state_d.rdata = UNMAPPED_READ;
      if (i_read) begin
         if (hit_freeze) begin
            state_d.rdata = state_q.freeze;
         end
         if (hit_status) begin
            state_d.rdata = state_q.latched_read_status;
         end
         for (int k = 0; k < NUM_WIDE; k++) begin
            if (hit_hi[k]) begin
               state_d.rdata = byte_hi[k]; // [RULE9]
            end
            if (hit_lo[k]) begin
               state_d.rdata = byte_lo[k]; // [RULE9]
            end
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state_q <= STATE_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_rdata                 = state_q.rdata;
   assign o_status_frozen         = state_q.frozen;
   assign o_base_rate_value       = state_q.base_rate;
   assign o_rate_multiplier_value = state_q.rate_mult;
   assign o_ref_zero_rate_hz      = state_q.rate_hz;
endmodule

/* verif/rfc_regs_assertions.sv */
// Checker for the reference rate register slice.
// Bound to rfc_regs; sees only the ports of that module.
`timescale 1ns/100ps
module rfc_regs_chk
   import rfc_pkg::*;
(
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic              i_write,
   input wire logic              i_read,
   input wire logic [DATA_W-1:0] i_status,
   input wire logic              i_clock,
   input wire logic              i_reset,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic              o_status_frozen,
   input wire logic [WORD_W-1:0] o_base_rate_value,
   input wire logic [WORD_W-1:0] o_rate_multiplier_value,
   input wire logic [PROD_W-1:0] o_ref_zero_rate_hz
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   logic [PROD_W-1:0] prod;
   assign prod = PROD_W'(o_base_rate_value)
               * PROD_W'(o_rate_multiplier_value);
   sequence s_wr(a);
      i_write && i_addr == a;
   endsequence
   property p_lock;
      s_wr(ADDR_FREEZE) ##0 i_wdata == FREEZE_LOCK |=> o_status_frozen;
   endproperty
   a_lock: assert property (p_lock) else $error("freeze missed");
   property p_free;
      s_wr(ADDR_FREEZE) ##0 i_wdata == FREEZE_RELEASE |=> !o_status_frozen;
   endproperty
   a_free: assert property (p_free) else $error("still frozen");
   property p_bhi;
      s_wr(ADDR_BASE_HI) |-> ##2 o_base_rate_value[15:8] == $past(i_wdata, 2);
   endproperty
   a_bhi: assert property (p_bhi) else $error("base hi");
   property p_mlo;
      s_wr(ADDR_MULT_LO) |-> ##2
         o_rate_multiplier_value[7:0] == $past(i_wdata, 2);
   endproperty
   a_mlo: assert property (p_mlo) else $error("mult lo");
   property p_rhi;
      i_read && i_addr == ADDR_MULT_HI |=>
         o_rdata == o_rate_multiplier_value[15:8];
   endproperty
   a_rhi: assert property (p_rhi) else $error("mult hi read");
   property p_rlo;
      i_read && i_addr == ADDR_BASE_LO |=> o_rdata == o_base_rate_value[7:0];
   endproperty
   a_rlo: assert property (p_rlo) else $error("base lo read");
   property p_prod;
      !i_reset |=> o_ref_zero_rate_hz == prod;
   endproperty
   a_prod: assert property (p_prod) else $error("product");
endmodule
bind rfc_regs rfc_regs_chk i_chk (.i_addr, .i_wdata, .i_write, .i_read,
   .i_status, .i_clock, .i_reset, .o_rdata, .o_status_frozen,
   .o_base_rate_value, .o_rate_multiplier_value, .o_ref_zero_rate_hz);

/* verif/rfc_regs_bench.sv */
// Self-checking bench for the reference rate register slice.
// Drives the byte register port itself; no partner model.
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module rfc_regs_bench;
   import rfc_pkg::*;
   logic i_clock = 0, i_reset = 1, i_write = 0, i_read = 0, pend = 0;
   logic [7:0] i_addr = '0, i_wdata = '0, i_status = '0, o_rdata, e;
   logic [15:0] o_base_rate_value, o_rate_multiplier_value;
   logic [31:0] o_ref_zero_rate_hz, seed = 32'h0000001F;
   logic o_status_frozen;
   logic [7:0] exp_q[$];
   int errors = 0, total_checks = 0;
   logic [15:0] codes[9] = '{16'h03E8, 16'h07D0, 16'h1388, 16'h186A,
      16'h1F40, 16'h2710, 16'h30D4, 16'h61A8, 16'h9C40};
   always #50 i_clock = ~i_clock;
   rfc_regs i_dut (.i_addr, .i_wdata, .i_write, .i_read, .i_status,
      .i_clock, .i_reset, .o_rdata, .o_status_frozen, .o_base_rate_value,
      .o_rate_multiplier_value, .o_ref_zero_rate_hz);
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      {i_addr, i_wdata, i_write} <= {a, d, 1'b1};
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      @(posedge i_clock);
      exp_q.push_back(x);
      {i_addr, i_read} <= {a, 1'b1};
      @(posedge i_clock);
      i_read <= 1'b0;
   endtask
   // Both halves read back, so a swapped byte order shows twice
   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[15:8]);
      wr(a + 8'h01, v[7:0]);
      rd(a, v[15:8]);
      rd(a + 8'h01, v[7:0]);
   endtask
   always @(negedge i_clock) begin
      if (pend) begin
         e = exp_q.pop_front();
         `CHK(o_rdata, e)
      end
      pend = i_read;
   end
   task automatic summarize;
      $display("checks=%0d errors=%0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Tests need about 130 cycles; 4000 cycles, near thirty times that, marks a hang
   initial begin
      #400000;
      errors++;
      summarize();
   end
   initial begin
      logic [15:0] m;
      logic [7:0] s;
      repeat (16) @(posedge i_clock);
      i_reset <= 1'b0;
      rd(ADDR_BASE_HI, 8'h9C);
      rd(ADDR_BASE_LO, 8'h40);
      rd(ADDR_MULT_HI, 8'h0F);
      rd(ADDR_MULT_LO, 8'h30);
      @(negedge i_clock);
      `CHK(o_ref_zero_rate_hz, 32'(BASE_RESET) * 32'(MULT_RESET))
      $display("reset test done");
      seed = xs(seed);
      m = seed[15:0];
      wr16(ADDR_MULT_HI, m);
      foreach (codes[k]) begin
         wr16(ADDR_BASE_HI, codes[k]);
         @(negedge i_clock);
         `CHK(o_base_rate_value, codes[k])
         `CHK(o_rate_multiplier_value, m)
         `CHK(o_ref_zero_rate_hz, 32'(codes[k]) * 32'(m))
      end
      // Halved input: the 155.52 MHz reference is programmed at half
      wr16(ADDR_MULT_HI, MULT_RESET >> 1);
      @(negedge i_clock);
      `CHK(o_ref_zero_rate_hz, 32'h04A28600)
      $display("rate test done");
      seed = xs(seed);
      s = seed[7:0];
      @(posedge i_clock);
      i_status <= s;
      wr(ADDR_FREEZE, FREEZE_LOCK);
      i_status <= ~s;
      rd(ADDR_STATUS, s);
      rd(ADDR_FREEZE, FREEZE_LOCK);
      @(negedge i_clock);
      `CHK(o_status_frozen, 1'b1)
      wr(ADDR_FREEZE, FREEZE_RELEASE);
      rd(ADDR_STATUS, ~s);
      rd(8'h20, UNMAPPED_READ);
      @(negedge i_clock);
      `CHK(o_status_frozen, 1'b0)
      $display("freeze test done");
      repeat (3) @(posedge i_clock);
      summarize();
   end
endmodule
